// ### rtl/logic_cell_params.svh
// constants for the programmable logic cell
//
// Functional notes
// - register works as D, T, JK or SR flipflop in normal mode, set by configuration; other modes load it as D.
// - clock, clear and preset come from a global, a pin or logic.
// - combinational use bypasses the flipflop; local and row/column outputs still pass an output register.
// - two independent outputs, local and row/column, lookup or register.
// - carry and cascade paths to the next cell skip local routing.
// - carry and cascade chains link every cell of a cluster and a row.
// - four modes: normal, arithmetic, up/down counter, clearable counter.
// - data inputs, feedback, carry-in and cascade-in are routed per mode.
// - three extra inputs give register clock, clear and preset.
// - synchronous enable in all modes, taken from the first lookup input.
// - four dedicated pins drive four globals, each overridable by logic.
`ifndef LOGIC_CELL_PARAMS_SVH
`define LOGIC_CELL_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CELL_DATA_W      4
`define CELL_GLOB_N      4
`define CELL_CTL_N       3
`define CELL_LUT_W       16

// ----------------------------------------------------------------
// data input positions
// ----------------------------------------------------------------
`define CELL_EN_BIT      0
`define CELL_DIR_BIT     2
`define CELL_SCLR_BIT    3
`define CELL_RESET_BIT   3

// ----------------------------------------------------------------
// control input positions
// ----------------------------------------------------------------
`define CELL_CTL_CLK     0
`define CELL_CTL_CLR     1
`define CELL_CTL_PRE     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CELL_REG_RST     1'b0
`define CELL_SYNC_RST    1'b0

`endif

// ### rtl/logic_cell_pkg.sv
// types of the programmable logic cell
package logic_cell_pkg;

   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'b00,
      MODE_ARITH     = 2'b01,
      MODE_UPDOWN    = 2'b10,
      MODE_CLEARABLE = 2'b11
   } cell_mode_t;

   typedef enum logic [1:0] {
      FF_D  = 2'b00,
      FF_T  = 2'b01,
      FF_JK = 2'b10,
      FF_SR = 2'b11
   } ff_type_t;

   typedef enum logic {
      OUT_LUT = 1'b0,
      OUT_REG = 1'b1
   } out_sel_t;

   typedef enum logic [1:0] {
      SRC_GLOBAL   = 2'b00,
      SRC_PIN      = 2'b01,
      SRC_INTERNAL = 2'b10,
      SRC_NONE     = 2'b11
   } ctl_src_t;

   typedef struct packed {
      ctl_src_t   src;
      logic [1:0] glob_idx;
   } ctl_route_t;

   typedef struct packed {
      cell_mode_t  mode;
      ff_type_t    ff_type;
      logic [15:0] lut_mask;
      out_sel_t    local_sel;
      out_sel_t    route_sel;
      logic        en_on;
      logic        cascade_on;
      ctl_route_t  clk_route;
      ctl_route_t  clr_route;
      ctl_route_t  pre_route;
   } cell_cfg_t;

endpackage : logic_cell_pkg

// ### rtl/ctrl_source_select.sv
// synchronisers and source selection for globals and register controls
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_params.svh"

module ctrl_source_select
   import logic_cell_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic [`CELL_GLOB_N-1:0]   ded_pin,
   input  wire logic [`CELL_GLOB_N-1:0]   glob_int,
   input  wire logic [`CELL_GLOB_N-1:0]   glob_int_sel,
   input  wire logic [`CELL_CTL_N-1:0]    gp_pin,
   input  wire logic [`CELL_CTL_N-1:0]    int_ctl,
   input  wire ctl_route_t                route [`CELL_CTL_N],
   output logic      [`CELL_GLOB_N-1:0]   glob,
   output logic      [`CELL_CTL_N-1:0]    ctl_lvl
);

   localparam int PIN_N = `CELL_GLOB_N + `CELL_CTL_N;

   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] meta_q;
   logic [PIN_N-1:0] sync_q;

   assign pin_raw = {gp_pin, ded_pin};

   // ----------------------------------------------------------------
   // two-stage synchronisers, one per pin
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < PIN_N; i++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               meta_q[i] <= `CELL_SYNC_RST;
               sync_q[i] <= `CELL_SYNC_RST;
            end
            else
            begin
               meta_q[i] <= pin_raw[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // globals and per-control source muxes
   // ----------------------------------------------------------------
   generate
      for (i = 0; i < `CELL_GLOB_N; i++)
      begin : g_glob
         // internal logic may take a global over, e.g. a divided clock
         assign glob[i] = glob_int_sel[i] ? glob_int[i]
                                          : sync_q[i];
      end
      for (i = 0; i < `CELL_CTL_N; i++)
      begin : g_ctl
         always_comb
         begin
            case (route[i].src)
               SRC_GLOBAL:   ctl_lvl[i] = glob[route[i].glob_idx];
               SRC_PIN:      ctl_lvl[i] = sync_q[`CELL_GLOB_N + i];
               SRC_INTERNAL: ctl_lvl[i] = int_ctl[i];
               default:      ctl_lvl[i] = 1'b0;
            endcase
         end
      end
   endgenerate

endmodule : ctrl_source_select
`default_nettype wire

// ### rtl/logic_cell.sv
// programmable logic cell: lookup table, configurable register, chains
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_params.svh"

module logic_cell
   import logic_cell_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire cell_cfg_t                cfg,
   input  wire logic [`CELL_DATA_W-1:0]  data_in,
   input  wire logic                     carry_in,
   input  wire logic                     cascade_in,
   input  wire logic [`CELL_GLOB_N-1:0]  ded_pin,
   input  wire logic [`CELL_GLOB_N-1:0]  glob_int,
   input  wire logic [`CELL_GLOB_N-1:0]  glob_int_sel,
   input  wire logic [`CELL_CTL_N-1:0]   gp_pin,
   input  wire logic [`CELL_CTL_N-1:0]   int_ctl,
   output logic                          carry_out,
   output logic                          cascade_out,
   output logic                          local_out,
   output logic                          route_out,
   output logic                          reg_out,
   output logic [`CELL_GLOB_N-1:0]       glob
);

   // ----------------------------------------------------------------
   // control sources: clock, clear, preset
   // ----------------------------------------------------------------
   ctl_route_t                routes [`CELL_CTL_N];
   logic [`CELL_CTL_N-1:0]    ctl_lvl;

   assign routes[`CELL_CTL_CLK] = cfg.clk_route;
   assign routes[`CELL_CTL_CLR] = cfg.clr_route;
   assign routes[`CELL_CTL_PRE] = cfg.pre_route;

   ctrl_source_select u_ctl (
      .clk          (clk),
      .reset        (reset),
      .ded_pin      (ded_pin),
      .glob_int     (glob_int),
      .glob_int_sel (glob_int_sel),
      .gp_pin       (gp_pin),
      .int_ctl      (int_ctl),
      .route        (routes),
      .glob         (glob),
      .ctl_lvl      (ctl_lvl)
   );

   logic clk_src_q;
   logic clk_tick;
   logic clr_act;
   logic pre_act;

   always_ff @(posedge clk)
   begin
      if (reset)
         clk_src_q <= 1'b0;
      else
         clk_src_q <= ctl_lvl[`CELL_CTL_CLK];
   end

   // a selected clock source acts on its rising edge; with no source the
   // register follows the core clock
   assign clk_tick = (cfg.clk_route.src == SRC_NONE) ? 1'b1
                   : (ctl_lvl[`CELL_CTL_CLK] & ~clk_src_q);
   assign clr_act  = ctl_lvl[`CELL_CTL_CLR];
   assign pre_act  = ctl_lvl[`CELL_CTL_PRE];

   // ----------------------------------------------------------------
   // lookup table
   // ----------------------------------------------------------------
   logic       reg_q;
   logic       reg_d;
   logic       reg_view;
   logic       lut_out;
   logic       sum_bit;
   logic       carry_gen;
   logic [2:0] arith_idx;

   // four-input table for normal mode
   assign lut_out = cfg.lut_mask[data_in];

   // arithmetic: low half gives the sum, high half the carry, both from
   // two operands and carry-in
   assign arith_idx = {carry_in, data_in[1], data_in[0]};
   assign sum_bit   = cfg.lut_mask[{1'b0, arith_idx}];
   assign carry_gen = cfg.lut_mask[{1'b1, arith_idx}];

   // ----------------------------------------------------------------
   // counter bit
   // ----------------------------------------------------------------
   logic count_up;
   logic count_bit;
   logic count_carry;
   logic sync_clr;

   assign count_up    = data_in[`CELL_DIR_BIT];
   // a cell toggles when the chain below it carries or borrows
   assign count_bit   = reg_view ^ carry_in;
   assign count_carry = count_up ? (reg_view & carry_in)
                                 : (~reg_view & carry_in);
   assign sync_clr    = (cfg.mode == MODE_CLEARABLE)
                      & data_in[`CELL_SCLR_BIT];

   // ----------------------------------------------------------------
   // mode-dependent data routing
   // ----------------------------------------------------------------
   logic mode_val;

   always_comb
   begin
      case (cfg.mode)
         MODE_NORMAL:
         begin
            mode_val  = lut_out;
            carry_out = 1'b0;
         end
         MODE_ARITH:
         begin
            mode_val  = sum_bit;
            carry_out = carry_gen;
         end
         MODE_UPDOWN, MODE_CLEARABLE:
         begin
            mode_val  = count_bit;
            carry_out = count_carry;
         end
         default:
         begin
            mode_val  = lut_out;
            carry_out = 1'b0;
         end
      endcase
   end

   // cascade joins this cell's table result with the previous cell's;
   // these chain outputs stay combinational so a whole row settles in
   // one core cycle, at the cost of a long path
   assign cascade_out = cfg.cascade_on ? (mode_val & cascade_in)
                                       : mode_val;

   // ----------------------------------------------------------------
   // configurable flipflop
   // ----------------------------------------------------------------
   logic ff_in_a;
   logic ff_in_b;
   logic reg_en;

   assign ff_in_a = cascade_out;
   assign ff_in_b = data_in[`CELL_RESET_BIT];

   // first lookup input doubles as the register enable when switched on
   assign reg_en = ~cfg.en_on | data_in[`CELL_EN_BIT];

   always_comb
   begin
      if (cfg.mode != MODE_NORMAL)
         reg_d = ff_in_a;
      else
      begin
         case (cfg.ff_type)
            FF_D:  reg_d = ff_in_a;
            FF_T:  reg_d = reg_q ^ ff_in_a;
            FF_JK: reg_d = (ff_in_a & ~reg_q) | (~ff_in_b & reg_q);
            // set and reset together hold the old value
            FF_SR: reg_d = (ff_in_a & ~ff_in_b) ? 1'b1
                         : (~ff_in_a & ff_in_b) ? 1'b0
                         : reg_q;
            default: reg_d = ff_in_a;
         endcase
      end
   end

   // clear wins over preset; both override any clock activity
   always_ff @(posedge clk)
   begin
      if (reset)
         reg_q <= `CELL_REG_RST;
      else if (clr_act)
         reg_q <= 1'b0;
      else if (pre_act)
         reg_q <= 1'b1;
      else if (clk_tick & reg_en)
      begin
         if (sync_clr)
            reg_q <= 1'b0;
         else
            reg_q <= reg_d;
      end
   end

   // clear and preset show at once, without waiting for the register
   assign reg_view = clr_act ? 1'b0
                   : pre_act ? 1'b1
                   : reg_q;

   assign reg_out = reg_view;

   // ----------------------------------------------------------------
   // two independent outputs
   // ----------------------------------------------------------------
   logic local_q;
   logic route_q;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         local_q <= 1'b0;
         route_q <= 1'b0;
      end
      else
      begin
         // lookup selection skips the configurable register but still passes through this output register
         local_q <= (cfg.local_sel == OUT_REG) ? reg_view
                                               : cascade_out;
         route_q <= (cfg.route_sel == OUT_REG) ? reg_view
                                               : cascade_out;
      end
   end

   assign local_out = local_q;
   assign route_out = route_q;

endmodule : logic_cell
`default_nettype wire

// ### bench/chain_peer.sv
// previous cell on the carry and cascade chains, prompt or a clock late
`timescale 1ns/10ps
`default_nettype none

module chain_peer
(
   input  wire logic clk,
   input  wire logic slow,
   input  wire logic carry_set,
   input  wire logic cascade_set,
   output logic      carry_in,
   output logic      cascade_in
);
   logic carry_q;
   logic cascade_q;

   // a slow neighbour shows its chain values only after its own register
   always_ff @(posedge clk) carry_q <= carry_set;
   always_ff @(posedge clk) cascade_q <= cascade_set;
   assign carry_in = slow ? carry_q : carry_set;
   assign cascade_in = slow ? cascade_q : cascade_set;
endmodule : chain_peer
`default_nettype wire

// ### bench/logic_cell_properties.sv
// concurrent checks on the logic cell ports
`timescale 1ns/10ps
`default_nettype none

module logic_cell_properties
   import logic_cell_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire cell_cfg_t  cfg,
   input wire logic [3:0] data_in,
   input wire logic       carry_in,
   input wire logic       cascade_in,
   input wire logic [3:0] ded_pin,
   input wire logic [3:0] glob_int,
   input wire logic [3:0] glob_int_sel,
   input wire logic [2:0] gp_pin,
   input wire logic [2:0] int_ctl,
   input wire logic       carry_out,
   input wire logic       cascade_out,
   input wire logic       local_out,
   input wire logic       route_out,
   input wire logic       reg_out,
   input wire logic [3:0] glob
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // plain: core clock every edge, nothing routed to clear or preset
   logic plain;
   logic en;
   assign plain = cfg.clk_route.src == SRC_NONE &&
      cfg.clr_route.src == SRC_NONE && cfg.pre_route.src == SRC_NONE;
   assign en = plain && (!cfg.en_on || data_in[0]);

   // the cascade gate sits in front of the register in every mode
   logic cas_ok;
   logic d_exp;
   logic sum_exp;
   logic cnt_exp;
   assign cas_ok  = !cfg.cascade_on || cascade_in;
   assign d_exp   = cfg.lut_mask[data_in] && cas_ok;
   assign sum_exp = cfg.lut_mask[{1'b0, carry_in, data_in[1:0]}] && cas_ok;
   assign cnt_exp = (reg_out ^ carry_in) && cas_ok;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_D_LOAD: assert property (
      cfg.mode == MODE_NORMAL && cfg.ff_type == FF_D && en
      |=> reg_out == $past(d_exp)) else $error("d load");
   AST_HOLD: assert property (
      plain && cfg.en_on && !data_in[0] |=> $stable(reg_out))
      else $error("disabled register moved");
   AST_LOCAL_LAG: assert property (
      cfg.local_sel == OUT_REG |=> local_out == $past(reg_out))
      else $error("local output not register");
   AST_ROUTE_LUT: assert property (
      cfg.route_sel == OUT_LUT |=> route_out == $past(cascade_out))
      else $error("row output not lookup");
   AST_CASCADE: assert property (
      cfg.cascade_on && !cascade_in |-> !cascade_out)
      else $error("cascade not gated");
   AST_ARITH_SUM: assert property (
      cfg.mode == MODE_ARITH && en |=> reg_out == $past(sum_exp))
      else $error("sum");
   AST_ARITH_CARRY: assert property (
      cfg.mode == MODE_ARITH |->
      carry_out == cfg.lut_mask[{1'b1, carry_in, data_in[1:0]}])
      else $error("arithmetic carry");
   AST_COUNT: assert property (
      cfg.mode == MODE_UPDOWN && en |=> reg_out == $past(cnt_exp))
      else $error("counter step");
   AST_BORROW: assert property (
      cfg.mode == MODE_UPDOWN && plain |-> carry_out ==
      (carry_in && (data_in[2] ? reg_out : !reg_out))) else $error("borrow");
   AST_SYNC_CLEAR: assert property (
      cfg.mode == MODE_CLEARABLE && en && data_in[3] |=> !reg_out)
      else $error("sync clear");
   AST_CLEAR: assert property (
      cfg.clr_route.src == SRC_INTERNAL && int_ctl[1] |-> !reg_out)
      else $error("clear ignored");
   AST_GLOB: assert property (
      (glob & glob_int_sel) == (glob_int & glob_int_sel))
      else $error("global source");

   cover property (cfg.mode == MODE_ARITH && carry_out);
   cover property (cfg.mode == MODE_CLEARABLE && en && data_in[3]);
   cover property (cfg.mode == MODE_UPDOWN && en && !data_in[2]);
endmodule : logic_cell_properties

bind logic_cell logic_cell_properties logic_cell_properties_inst (
   .clk, .reset, .cfg, .data_in, .carry_in, .cascade_in, .ded_pin,
   .glob_int, .glob_int_sel, .gp_pin, .int_ctl, .carry_out,
   .cascade_out, .local_out, .route_out, .reg_out, .glob);
`default_nettype wire

// ### bench/logic_cell_test.sv
// self-checking bench of the logic cell
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   fail_count++; $display("Error at %0t: output mismatch", $time); end end

module logic_cell_test
   import logic_cell_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   cell_cfg_t  cfg = '0;
   cell_cfg_t  c;
   logic [3:0] data_in = 4'h0;
   logic [3:0] ded_pin = 4'h0;
   logic [3:0] glob_int = 4'h0;
   logic [3:0] glob_int_sel = 4'h0;
   logic [2:0] gp_pin = 3'h0;
   logic [2:0] int_ctl = 3'h0;
   logic       slow = 1'b0;
   logic       carry_set = 1'b0;
   logic       cascade_set = 1'b0;
   logic       carry_in, cascade_in, carry_out, cascade_out;
   logic       local_out, route_out, reg_out;
   logic [3:0] glob;
   int         fail_count = 0;
   int         total_checks = 0;
   int         cycles = 0;
   logic [3:0] ff_seq [4] = '{4'h1, 4'h1, 4'h3, 4'h9};
   logic [3:0] ff_exp [4] = '{4'b1101, 4'b1001, 4'b1110, 4'b1111};

   logic_cell logic_cell_inst (.clk, .reset, .cfg, .data_in, .carry_in,
      .cascade_in, .ded_pin, .glob_int, .glob_int_sel, .gp_pin, .int_ctl,
      .carry_out, .cascade_out, .local_out, .route_out, .reg_out, .glob);
   chain_peer chain_peer_inst (.clk, .slow, .carry_set, .cascade_set,
      .carry_in, .cascade_in);

   always #4 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   // the run takes about a hundred cycles; anything far beyond is a hang
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         end_sim();
      end
   end

   function automatic cell_cfg_t base(cell_mode_t m, ff_type_t f,
                                      logic [15:0] k);
      base = '0;
      base.mode = m;
      base.ff_type = f;
      base.lut_mask = k;
      base.local_sel = OUT_REG;
      base.en_on = 1'b1;
      base.clk_route.src = SRC_NONE;
      base.clr_route.src = SRC_NONE;
      base.pre_route.src = SRC_NONE;
   endfunction : base

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // configuration only changes while the cell is held in reset
   task automatic setup(input cell_cfg_t v);
      reset = 1'b1;
      cfg = v;
      tick(3);
      reset = 1'b0;
   endtask : setup

   task automatic step(input logic [3:0] d);
      data_in = d;
      tick(1);
   endtask : step

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      tick(10);
      setup(base(MODE_NORMAL, FF_D, 16'h8000));
      step(4'hf);
      `CHK(reg_out, 1'b1)
      `CHK(route_out, 1'b1)
      step(4'he);
      `CHK(reg_out, 1'b1)
      `CHK(local_out, 1'b1)
      `CHK(route_out, 1'b0)
      step(4'h1);
      `CHK(reg_out, 1'b0)
      $display("normal mode test done");
      for (int t = 0; t < 4; t++)
      begin
         setup(base(MODE_NORMAL, ff_type_t'(t[1:0]), 16'h0202));
         for (int s = 0; s < 4; s++)
         begin
            step(ff_seq[s]);
            `CHK(reg_out, ff_exp[t][3 - s])
         end
      end
      $display("flipflop type test done");
      c = base(MODE_ARITH, FF_D, 16'he896);
      c.en_on = 1'b0;
      setup(c);
      for (int i = 0; i < 8; i++)
      begin
         carry_set = i[2];
         data_in = {2'b00, i[1:0]};
         tick(1);
         `CHK(reg_out, ^i[2:0])
         `CHK(cascade_out, ^i[2:0])
         `CHK(carry_out, i[2:0] inside {3, 5, 6, 7})
      end
      $display("arithmetic test done");
      slow = 1'b1;
      carry_set = 1'b1;
      setup(base(MODE_UPDOWN, FF_D, 16'h0000));
      step(4'h5);
      `CHK(reg_out, 1'b1)
      `CHK(carry_out, 1'b1)
      step(4'h1);
      `CHK(reg_out, 1'b0)
      `CHK(carry_out, 1'b1)
      step(4'h4);
      `CHK(reg_out, 1'b0)
      `CHK(carry_out, 1'b0)
      setup(base(MODE_CLEARABLE, FF_D, 16'h0000));
      step(4'h1);
      `CHK(reg_out, 1'b1)
      step(4'h8);
      `CHK(reg_out, 1'b1)
      step(4'h9);
      `CHK(reg_out, 1'b0)
      $display("counter test done");
      c = base(MODE_NORMAL, FF_D, 16'h0000);
      c.clr_route.src = SRC_INTERNAL;
      c.pre_route.src = SRC_INTERNAL;
      setup(c);
      // enable off, so only preset and clear move the register
      data_in = 4'h0;
      int_ctl = 3'b100;
      tick(2);
      `CHK(reg_out, 1'b1)
      int_ctl = 3'b000;
      tick(1);
      `CHK(reg_out, 1'b1)
      int_ctl = 3'b110;
      tick(1);
      `CHK(reg_out, 1'b0)
      int_ctl = 3'b000;
      tick(1);
      `CHK(reg_out, 1'b0)
      $display("clear and preset test done");
      c = base(MODE_NORMAL, FF_T, 16'hffff);
      c.clk_route.src = SRC_INTERNAL;
      setup(c);
      data_in = 4'h1;
      tick(2);
      `CHK(reg_out, 1'b0)
      int_ctl = 3'b001;
      tick(4);
      `CHK(reg_out, 1'b1)
      int_ctl = 3'b000;
      tick(2);
      int_ctl = 3'b001;
      tick(2);
      `CHK(reg_out, 1'b0)
      $display("internal clock test done");
      c = base(MODE_NORMAL, FF_D, 16'hffff);
      c.cascade_on = 1'b1;
      setup(c);
      slow = 1'b0;
      cascade_set = 1'b0;
      glob_int_sel = 4'b1010;
      glob_int = 4'b1000;
      ded_pin = 4'b0101;
      step(4'h1);
      `CHK(cascade_out, 1'b0)
      `CHK(route_out, 1'b0)
      cascade_set = 1'b1;
      tick(3);
      `CHK(cascade_out, 1'b1)
      `CHK(route_out, 1'b1)
      `CHK(glob, 4'b1101)
      `CHK(reg_out, 1'b1)
      $display("cascade and global test done");
      c = base(MODE_NORMAL, FF_D, 16'h0000);
      c.clr_route.src = SRC_PIN;
      c.pre_route.src = SRC_GLOBAL;
      c.pre_route.glob_idx = 2'h1;
      setup(c);
      data_in = 4'h0;
      glob_int = 4'b1010;
      tick(1);
      `CHK(reg_out, 1'b1)
      glob_int = 4'b1000;
      gp_pin = 3'b010;
      tick(1);
      `CHK(reg_out, 1'b1)
      tick(1);
      `CHK(reg_out, 1'b0)
      $display("pin and global source test done");
      end_sim();
   end
endmodule : logic_cell_test
`default_nettype wire
